// [src/inr_detector.sv]
// Notes on behaviour
// - A phase flags inrush when second harmonic over fundamental exceeds ratio setting.
// - Ratio setting takes 5 to 50 percent in whole steps, default 15.
// - A phase flag needs its fundamental above the sensitivity level.
// - Sensitivity takes 20 to 100 percent of rated, whole steps, default 30.
// - Each phase is judged alone from its own magnitudes.
// - The general flag is high while any phase flag is high.
// - While the block input is high all flags are held low.
// - Each change of the general flag gives an on or off event.
`timescale 1ns/10ps
`default_nettype none
module inr_detector
(
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [inr_pkg::ADR_W-1:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire inr_pkg::inr_mag3_t FUND_MAG,
	input wire inr_pkg::inr_mag3_t HARM2_MAG,
	input wire logic INRUSH_BLOCK_INPUT,
	output logic INRUSH_PHASE1_FLAG,
	output logic INRUSH_PHASE2_FLAG,
	output logic INRUSH_PHASE3_FLAG,
	output logic INRUSH_ANY_PHASE_FLAG,
	output logic EVENT_STB,
	output logic EVENT_VALUE,
	output logic IRQ
);
	import inr_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed
	{
		logic en;
		inr_ratio_t ratio;
		inr_sens_t sens;
		logic ack;
		logic [31:0] rdat;
		logic any_flag;
		logic evt_stb;
		logic evt_val;
	} inr_top_s;

	inr_top_s st_r;
	inr_top_s st_nxt;

	logic [NPH-1:0] ph_flag;
	inr_irq_t irq_set;
	inr_irq_t irq_stat;
	inr_irq_t irq_mask;
	logic bus_req;
	logic wr_lo;
	logic clr_we;
	logic mask_we;
	logic any_nxt;
	logic [31:0] rd_word;

	////////////////////////////////////////////////////////////////////////////////
	// Per-phase detectors

	inr_phase_if ph_bus[NPH]();

	generate
		for (genvar g = 0; g < NPH; g++)
		begin : g_ph
			// Each phase sees only its own magnitudes
			assign ph_bus[g].fund = FUND_MAG[g];
			assign ph_bus[g].harm2 = HARM2_MAG[g];
			assign ph_bus[g].ratio = st_r.ratio;
			assign ph_bus[g].sens = st_r.sens;
			assign ph_bus[g].run = st_r.en && !INRUSH_BLOCK_INPUT;
			assign ph_flag[g] = ph_bus[g].flag;

			inr_phase_det u_det
			(
				.clk(MCLK),
				.rst_n(RESETN),
				.ph(ph_bus[g].det)
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode

	assign bus_req = WB_CYC_I && WB_STB_I && !st_r.ack;
	assign wr_lo = bus_req && WB_WE_I && WB_SEL_I[0];
	assign clr_we = wr_lo && (WB_ADR_I == ADDR_IRQ_STAT);
	assign mask_we = wr_lo && (WB_ADR_I == ADDR_IRQ_MASK);

	always_comb
	begin
		rd_word = '0;
		case (WB_ADR_I)
			ADDR_CTRL:
			begin
				rd_word[CTRL_EN_BIT] = st_r.en;
			end
			ADDR_RATIO:
			begin
				rd_word[$bits(inr_ratio_t)-1:0] = st_r.ratio;
			end
			ADDR_SENS:
			begin
				rd_word[$bits(inr_sens_t)-1:0] = st_r.sens;
			end
			ADDR_STATUS:
			begin
				rd_word[ST_ANY_BIT] = st_r.any_flag;
				rd_word[ST_PH_LSB+NPH-1:ST_PH_LSB] = ph_flag;
				rd_word[ST_BLOCK_BIT] = INRUSH_BLOCK_INPUT;
				rd_word[ST_EN_BIT] = st_r.en;
			end
			ADDR_IRQ_STAT:
			begin
				rd_word[IRQ_W-1:0] = irq_stat;
			end
			ADDR_IRQ_MASK:
			begin
				rd_word[IRQ_W-1:0] = irq_mask;
			end
			default:
			begin
				rd_word = '0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	assign any_nxt = |ph_flag;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.ack = bus_req;
		st_nxt.rdat = bus_req ? rd_word : st_r.rdat;
		if (wr_lo && (WB_ADR_I == ADDR_CTRL))
		begin
			st_nxt.en = WB_DAT_I[CTRL_EN_BIT];
		end
		// Out-of-range settings are ignored
		if (wr_lo && (WB_ADR_I == ADDR_RATIO)
			&& (WB_DAT_I[7:0] >= 8'(RATIO_MIN)) && (WB_DAT_I[7:0] <= 8'(RATIO_MAX)))
		begin
			st_nxt.ratio = WB_DAT_I[$bits(inr_ratio_t)-1:0];
		end
		if (wr_lo && (WB_ADR_I == ADDR_SENS)
			&& (WB_DAT_I[7:0] >= 8'(SENS_MIN)) && (WB_DAT_I[7:0] <= 8'(SENS_MAX)))
		begin
			st_nxt.sens = WB_DAT_I[$bits(inr_sens_t)-1:0];
		end
		st_nxt.any_flag = any_nxt;
		st_nxt.evt_stb = any_nxt != st_r.any_flag;
		st_nxt.evt_val = (any_nxt != st_r.any_flag) ? any_nxt : st_r.evt_val;
	end

	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			st_r <= '0;
			st_r.ratio <= RATIO_RST;
			st_r.sens <= SENS_RST;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupts

	always_comb
	begin
		irq_set = '0;
		irq_set[IRQ_ON_BIT] = st_r.evt_stb && st_r.evt_val;
		irq_set[IRQ_OFF_BIT] = st_r.evt_stb && !st_r.evt_val;
	end

	inr_irq u_irq
	(
		.clk(MCLK),
		.rst_n(RESETN),
		.set(irq_set),
		.clr_we(clr_we),
		.clr_data(WB_DAT_I[IRQ_W-1:0]),
		.mask_we(mask_we),
		.mask_data(WB_DAT_I[IRQ_W-1:0]),
		.stat(irq_stat),
		.mask(irq_mask),
		.irq(IRQ)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign WB_ACK_O = st_r.ack;
	assign WB_DAT_O = st_r.rdat;
	assign INRUSH_PHASE1_FLAG = ph_flag[0];
	assign INRUSH_PHASE2_FLAG = ph_flag[1];
	assign INRUSH_PHASE3_FLAG = ph_flag[2];
	assign INRUSH_ANY_PHASE_FLAG = st_r.any_flag;
	assign EVENT_STB = st_r.evt_stb;
	assign EVENT_VALUE = st_r.evt_val;
endmodule
`default_nettype wire

// [src/inr_pkg.sv]
package inr_pkg;
	// Magnitudes from the Fourier stage
	localparam int MAG_W = 16;
	localparam int NPH = 3;
	localparam int PROD_W = 24;
	typedef logic [MAG_W-1:0] inr_mag_t;
	typedef logic [NPH-1:0][MAG_W-1:0] inr_mag3_t;
	typedef logic [5:0] inr_ratio_t;
	typedef logic [6:0] inr_sens_t;
	typedef logic [1:0] inr_irq_t;

	// Magnitude code that stands for 100 % rated current
	localparam inr_mag_t RATED_MAG = 16'h0400;
	localparam logic [PROD_W-1:0] PCT_SCALE = 24'h00_0064;

	// Setting limits and reset values, whole percent
	localparam inr_ratio_t RATIO_MIN = 6'h05;
	localparam inr_ratio_t RATIO_MAX = 6'h32;
	localparam inr_ratio_t RATIO_RST = 6'h0F;
	localparam inr_sens_t SENS_MIN = 7'h14;
	localparam inr_sens_t SENS_MAX = 7'h64;
	localparam inr_sens_t SENS_RST = 7'h1E;

	// Register byte offsets
	localparam int ADR_W = 8;
	localparam logic [ADR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADR_W-1:0] ADDR_RATIO = 8'h04;
	localparam logic [ADR_W-1:0] ADDR_SENS = 8'h08;
	localparam logic [ADR_W-1:0] ADDR_STATUS = 8'h0C;
	localparam logic [ADR_W-1:0] ADDR_IRQ_STAT = 8'h10;
	localparam logic [ADR_W-1:0] ADDR_IRQ_MASK = 8'h14;

	// Field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int ST_ANY_BIT = 0;
	localparam int ST_PH_LSB = 1;
	localparam int ST_BLOCK_BIT = 4;
	localparam int ST_EN_BIT = 5;
	localparam int IRQ_ON_BIT = 0;
	localparam int IRQ_OFF_BIT = 1;
	localparam int IRQ_W = 2;
endpackage

// [src/inr_phase_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface inr_phase_if;
	import inr_pkg::*;
	inr_mag_t fund;
	inr_mag_t harm2;
	inr_ratio_t ratio;
	inr_sens_t sens;
	logic run;
	logic flag;
	modport src (output fund, output harm2, output ratio, output sens, output run, input flag);
	modport det (input fund, input harm2, input ratio, input sens, input run, output flag);
endinterface
`default_nettype wire

// [src/inr_phase_det.sv]
`timescale 1ns/10ps
`default_nettype none
module inr_phase_det
(
	input wire logic clk,
	input wire logic rst_n,
	inr_phase_if.det ph
);
	import inr_pkg::*;

	typedef struct packed
	{
		logic flag;
	} inr_phase_s;

	inr_phase_s st_r;
	inr_phase_s st_nxt;
	logic [PROD_W-1:0] harm_scaled;
	logic [PROD_W-1:0] fund_scaled;
	logic [PROD_W-1:0] fund_pct;
	logic [PROD_W-1:0] sens_level;

	always_comb
	begin
		// Ratio test without division
		harm_scaled = PROD_W'(ph.harm2) * PCT_SCALE;
		fund_scaled = PROD_W'(ph.fund) * PROD_W'(ph.ratio);
		fund_pct = PROD_W'(ph.fund) * PCT_SCALE;
		sens_level = PROD_W'(RATED_MAG) * PROD_W'(ph.sens);
		st_nxt = st_r;
		st_nxt.flag = ph.run
			&& (fund_pct > sens_level)
			&& (harm_scaled > fund_scaled);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign ph.flag = st_r.flag;
endmodule
`default_nettype wire

// [src/inr_irq.sv]
`timescale 1ns/10ps
`default_nettype none
module inr_irq
(
	input wire logic clk,
	input wire logic rst_n,
	input wire inr_pkg::inr_irq_t set,
	input wire logic clr_we,
	input wire inr_pkg::inr_irq_t clr_data,
	input wire logic mask_we,
	input wire inr_pkg::inr_irq_t mask_data,
	output inr_pkg::inr_irq_t stat,
	output inr_pkg::inr_irq_t mask,
	output logic irq
);
	import inr_pkg::*;

	typedef struct packed
	{
		inr_irq_t stat;
		inr_irq_t mask;
	} inr_irqst_s;

	inr_irqst_s st_r;
	inr_irqst_s st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		// Set wins over a write-one clear in the same cycle
		if (clr_we)
		begin
			st_nxt.stat = st_r.stat & ~clr_data;
		end
		st_nxt.stat = st_nxt.stat | set;
		if (mask_we)
		begin
			st_nxt.mask = mask_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign stat = st_r.stat;
	assign mask = st_r.mask;
	assign irq = |(st_r.stat & st_r.mask);
endmodule
`default_nettype wire

// [dv/inr_fourier_src.sv]
`timescale 1ns/10ps
`default_nettype none
module inr_fourier_src
(
	input wire logic clk,
	input wire inr_pkg::inr_mag3_t fund_set,
	input wire inr_pkg::inr_mag3_t harm2_set,
	output inr_pkg::inr_mag3_t fund,
	output inr_pkg::inr_mag3_t harm2
);
	import inr_pkg::*;
	// Both magnitudes of every phase refreshed each cycle
	always_ff @(posedge clk)
	begin
		fund <= fund_set;
		harm2 <= harm2_set;
	end
endmodule
`default_nettype wire

// [dv/inr_detector_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module inr_detector_monitor
(
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_ACK_O,
	input wire inr_pkg::inr_mag3_t FUND_MAG,
	input wire inr_pkg::inr_mag3_t HARM2_MAG,
	input wire logic INRUSH_BLOCK_INPUT,
	input wire logic INRUSH_PHASE1_FLAG,
	input wire logic INRUSH_PHASE2_FLAG,
	input wire logic INRUSH_PHASE3_FLAG,
	input wire logic INRUSH_ANY_PHASE_FLAG,
	input wire logic EVENT_STB,
	input wire logic EVENT_VALUE
);
	import inr_pkg::*;
	wire logic [2:0] ph = {INRUSH_PHASE3_FLAG, INRUSH_PHASE2_FLAG, INRUSH_PHASE1_FLAG};
	wire logic any = INRUSH_ANY_PHASE_FLAG;
	// Below the lowest ratio or sensitivity no setting can flag
	wire logic low_h = 24'(HARM2_MAG[1]) * PCT_SCALE <= 24'(FUND_MAG[1]) * 24'(RATIO_MIN);
	wire logic low_f = FUND_MAG[0] <= 16'h00CC;
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RESETN);
	sequence s_new_req;
		WB_CYC_I && WB_STB_I && !WB_ACK_O;
	endsequence
	a_ack_follows: assert property (s_new_req |=> WB_ACK_O)
		else $error("no ack");
	a_ratio_floor: assert property (low_h |=> !ph[1])
		else $error("ratio floor");
	a_fund_floor: assert property (low_f |=> !ph[0])
		else $error("fund floor");
	a_block_phases: assert property (INRUSH_BLOCK_INPUT |=> ph == 3'h0)
		else $error("block phase");
	a_block_general: assert property (INRUSH_BLOCK_INPUT |=> ##1 !any)
		else $error("block any");
	a_general_or: assert property (any == $past(|ph))
		else $error("any flag");
	a_event_change: assert property (EVENT_STB == (any != $past(any)))
		else $error("event strobe");
	a_event_value: assert property (EVENT_STB |-> EVENT_VALUE == any)
		else $error("event value");
endmodule
`default_nettype wire

// [dv/test_inr_detector.sv]
`timescale 1ns/10ps
`default_nettype none
module test_inr_detector;
	import inr_pkg::*;
	logic MCLK = 1'b0;
	logic RESETN = 1'b0;
	logic WB_CYC_I = 1'b0;
	logic WB_STB_I = 1'b0;
	logic WB_WE_I = 1'b0;
	logic [3:0] WB_SEL_I = 4'hF;
	logic [3:0] sel_v = 4'hF;
	logic INRUSH_BLOCK_INPUT = 1'b0;
	logic [7:0] WB_ADR_I = 8'h00;
	logic [31:0] WB_DAT_I = 32'h0000_0000;
	logic [31:0] WB_DAT_O, rv;
	logic WB_ACK_O, INRUSH_PHASE1_FLAG, INRUSH_PHASE2_FLAG, INRUSH_PHASE3_FLAG;
	logic INRUSH_ANY_PHASE_FLAG, EVENT_STB, EVENT_VALUE, IRQ;
	inr_mag3_t fs = '0;
	inr_mag3_t hs = '0;
	inr_mag3_t FUND_MAG, HARM2_MAG;
	inr_mag_t tf [4] = '{16'h03E8, 16'h03E8, 16'h0133, 16'h0134};
	inr_mag_t th [4] = '{16'h0096, 16'h0097, 16'h00C8, 16'h00C8};
	logic te [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
	int err_total = 0;
	int num_checks = 0;
	initial forever #5 MCLK = ~MCLK;
	inr_fourier_src SRC (.clk(MCLK), .fund_set(fs), .harm2_set(hs), .fund(FUND_MAG),
		.harm2(HARM2_MAG));
	inr_detector DUT (.MCLK, .RESETN, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
		.WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .FUND_MAG, .HARM2_MAG,
		.INRUSH_BLOCK_INPUT, .INRUSH_PHASE1_FLAG, .INRUSH_PHASE2_FLAG, .INRUSH_PHASE3_FLAG,
		.INRUSH_ANY_PHASE_FLAG, .EVENT_STB, .EVENT_VALUE, .IRQ);
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		WB_CYC_I <= 1'b1;
		WB_STB_I <= 1'b1;
		WB_WE_I <= w;
		WB_SEL_I <= sel_v;
		WB_ADR_I <= a;
		WB_DAT_I <= d;
		do
			@(posedge MCLK);
		while (WB_ACK_O !== 1'b1);
		rv = WB_DAT_O;
		WB_CYC_I <= 1'b0;
		WB_STB_I <= 1'b0;
		@(posedge MCLK);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		chk($sformatf("reg %h", a), e, rv);
	endtask
	task automatic put(input logic [7:0] a, input logic [31:0] v, input logic [31:0] e);
		wb(1'b1, a, v);
		rd(a, e);
	endtask
	task automatic ph(input int p, input inr_mag_t f, input inr_mag_t h, input logic [3:0] e);
		fs[p] <= f;
		hs[p] <= h;
		repeat (5) @(posedge MCLK);
		chk("flags", e, {INRUSH_PHASE3_FLAG, INRUSH_PHASE2_FLAG, INRUSH_PHASE1_FLAG,
			INRUSH_ANY_PHASE_FLAG});
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		#100000;
		err_total++;
		close_out();
	end
	initial
	begin
		repeat (12) @(posedge MCLK);
		RESETN <= 1'b1;
		@(posedge MCLK);
		rd(ADDR_CTRL, 32'h0000_0000);
		rd(ADDR_RATIO, 32'h0000_000F);
		rd(ADDR_SENS, 32'h0000_001E);
		ph(0, 16'h0400, 16'h0200, 4'h0);
		wb(1'b1, ADDR_IRQ_MASK, 32'h0000_0003);
		wb(1'b1, ADDR_CTRL, 32'h0000_0001);
		ph(1, 16'h0400, 16'h0010, 4'h3);
		chk("irq", 1'b1, IRQ);
		chk("event on", 1'b1, EVENT_VALUE);
		rd(ADDR_IRQ_STAT, 32'h0000_0001);
		wb(1'b1, ADDR_IRQ_STAT, 32'h0000_0001);
		chk("irq", 1'b0, IRQ);
		ph(0, 16'h0000, 16'h0000, 4'h0);
		chk("event off", 1'b0, EVENT_VALUE);
		rd(ADDR_IRQ_STAT, 32'h0000_0002);
		wb(1'b1, ADDR_IRQ_MASK, 32'h0000_0000);
		chk("irq", 1'b0, IRQ);
		wb(1'b1, ADDR_IRQ_STAT, 32'h0000_0003);
		for (int p = 0; p < 3; p++)
			for (int i = 0; i < 4; i++)
			begin
				ph(p, tf[i], th[i], te[i] ? 4'((2 << p) | 1) : 4'h0);
				ph(p, 16'h0000, 16'h0000, 4'h0);
			end
		put(ADDR_RATIO, 32'h0000_0004, 32'h0000_000F);
		put(ADDR_RATIO, 32'h0000_0033, 32'h0000_000F);
		put(ADDR_RATIO, 32'h0000_0032, 32'h0000_0032);
		// Low byte not selected: write dropped
		sel_v = 4'hE;
		wb(1'b1, ADDR_RATIO, 32'h0000_0014);
		sel_v = 4'hF;
		rd(ADDR_RATIO, 32'h0000_0032);
		put(ADDR_SENS, 32'h0000_0013, 32'h0000_001E);
		put(ADDR_SENS, 32'h0000_0065, 32'h0000_001E);
		put(ADDR_SENS, 32'h0000_0064, 32'h0000_0064);
		ph(0, 16'h0400, 16'h0258, 4'h0);
		ph(0, 16'h0401, 16'h0200, 4'h0);
		ph(0, 16'h0401, 16'h0201, 4'h3);
		INRUSH_BLOCK_INPUT <= 1'b1;
		ph(0, 16'h0401, 16'h0201, 4'h0);
		rd(ADDR_STATUS, 32'h0000_0030);
		INRUSH_BLOCK_INPUT <= 1'b0;
		ph(0, 16'h0401, 16'h0201, 4'h3);
		rd(ADDR_STATUS, 32'h0000_0023);
		rd(8'h20, 32'h0000_0000);
		close_out();
	end
endmodule
bind inr_detector inr_detector_monitor MON (.MCLK, .RESETN, .WB_CYC_I, .WB_STB_I,
	.WB_ACK_O, .FUND_MAG, .HARM2_MAG, .INRUSH_BLOCK_INPUT, .INRUSH_PHASE1_FLAG,
	.INRUSH_PHASE2_FLAG, .INRUSH_PHASE3_FLAG, .INRUSH_ANY_PHASE_FLAG, .EVENT_STB,
	.EVENT_VALUE);
`default_nettype wire
